// *** logic/twc_timer_channel.v ***
// Timer channel in waveform mode with compare A/B/C and gray stepper output
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ps
`include "twc_defs.vh"

module twc_timer_channel (
  input wire clk,
  input wire reset,
  input wire [31:0] addr,
  input wire [31:0] wdata,
  input wire wr,
  input wire rd,
  output reg [31:0] rdata,
  input wire ext_event,
  output reg output_a,
  output reg output_b
);

  // ==========================================
  // Registers
  reg [31:0] mode_reg;
  reg [1:0] stepper_reg;
  reg protect_reg;
  reg [`TWC_CW-1:0] compare_a_reg;
  reg [`TWC_CW-1:0] compare_b_reg;
  reg [`TWC_CW-1:0] compare_c_reg;
  reg [`TWC_CW-1:0] count_reg;
  reg [`TWC_CW-1:0] count_next;
  reg dir_down_reg;
  reg dir_down_next;
  reg running_reg;
  reg wave_a_reg;
  reg wave_a_next;
  reg wave_b_reg;
  reg wave_b_next;
  reg [1:0] gray_reg;
  reg [1:0] gray_next;
  reg ext_s1_reg;
  reg ext_s2_reg;
  reg ext_s3_reg;

  // ==========================================
  // Decode
  wire wave = mode_reg[`TWC_MODE_WAVE];
  wire [1:0] shape = mode_reg[`TWC_MODE_SHAPE_HI:`TWC_MODE_SHAPE_LO];
  wire [1:0] edge_sel = mode_reg[`TWC_MODE_EDGE_HI:`TWC_MODE_EDGE_LO];
  wire ext_restart = mode_reg[`TWC_MODE_EXT_RESTART];
  wire gray_count_enable = stepper_reg[`TWC_STEP_GRAY];
  wire gray_down = stepper_reg[`TWC_STEP_DOWN];
  wire write_protect_enable = protect_reg;
  wire wr_ctl = wr && (addr == `TWC_ADDR_CONTROL);
  wire wr_open = wr && !write_protect_enable;
  wire soft_trigger = wr_ctl && wdata[`TWC_CTL_SWTRIG];

  // ==========================================
  // Register selects and accepted writes
  wire sel_mode = (addr == `TWC_ADDR_MODE);
  wire sel_stepper = (addr == `TWC_ADDR_STEPPER);
  wire sel_cmp_a = (addr == `TWC_ADDR_CMP_A);
  wire sel_cmp_b = (addr == `TWC_ADDR_CMP_B);
  wire sel_cmp_c = (addr == `TWC_ADDR_CMP_C);
  wire sel_protect = (addr == `TWC_ADDR_PROTECT);
  // Compare A/B are read-only while the channel is out of waveform mode
  wire wr_mode = wr_open && sel_mode;
  wire wr_stepper = wr_open && sel_stepper;
  wire wr_cmp_a = wr_open && wave && sel_cmp_a;
  wire wr_cmp_b = wr_open && wave && sel_cmp_b;
  wire wr_cmp_c = wr_open && sel_cmp_c;
  wire wr_protect = wr && sel_protect;

  wire [1:0] out_a_on_compare_a = mode_reg[`TWC_MODE_A_CMPA_LO+1:`TWC_MODE_A_CMPA_LO];
  wire [1:0] out_a_on_compare_c = mode_reg[`TWC_MODE_A_CMPC_LO+1:`TWC_MODE_A_CMPC_LO];
  wire [1:0] out_a_on_ext_event = mode_reg[`TWC_MODE_A_EXT_LO+1:`TWC_MODE_A_EXT_LO];
  wire [1:0] out_a_on_soft_trigger = mode_reg[`TWC_MODE_A_SW_LO+1:`TWC_MODE_A_SW_LO];
  wire [1:0] out_b_on_compare_b = mode_reg[`TWC_MODE_B_CMPB_LO+1:`TWC_MODE_B_CMPB_LO];
  wire [1:0] out_b_on_compare_c = mode_reg[`TWC_MODE_B_CMPC_LO+1:`TWC_MODE_B_CMPC_LO];
  wire [1:0] out_b_on_ext_event = mode_reg[`TWC_MODE_B_EXT_LO+1:`TWC_MODE_B_EXT_LO];
  wire [1:0] out_b_on_soft_trigger = mode_reg[`TWC_MODE_B_SW_LO+1:`TWC_MODE_B_SW_LO];

  // ==========================================
  // External event edge detect
  // Only the second and third stages feed the detector; the first may be metastable
  wire ext_rise = ext_s2_reg && !ext_s3_reg;
  wire ext_fall = !ext_s2_reg && ext_s3_reg;
  reg ext_edge;

  always @* begin
    case (edge_sel)
      `TWC_EDGE_RISE: ext_edge = ext_rise;
      `TWC_EDGE_FALL: ext_edge = ext_fall;
      `TWC_EDGE_BOTH: ext_edge = ext_rise || ext_fall;
      default: ext_edge = 1'b0;
    endcase
  end

  wire ext_hit = ext_edge && running_reg;

  // ==========================================
  // Compare events, waveform mode only
  wire hit_a = wave && running_reg && (count_reg == compare_a_reg);
  wire hit_b = wave && running_reg && (count_reg == compare_b_reg);
  wire hit_c = wave && running_reg && (count_reg == compare_c_reg);

  // ==========================================
  // Output action
  function act;
    input cur;
    input [1:0] code;
    begin
      case (code)
        `TWC_ACT_SET: act = 1'b1;
        `TWC_ACT_CLEAR: act = 1'b0;
        `TWC_ACT_TOGGLE: act = !cur;
        default: act = cur;
      endcase
    end
  endfunction

  // Highest priority event decides alone; lower ones in the same cycle are dropped
  always @* begin
    wave_a_next = wave_a_reg;
    wave_b_next = wave_b_reg;
    if (wave) begin
      if (soft_trigger) begin
        wave_a_next = act(wave_a_reg, out_a_on_soft_trigger);
      end else if (ext_hit) begin
        wave_a_next = act(wave_a_reg, out_a_on_ext_event);
      end else if (hit_c) begin
        wave_a_next = act(wave_a_reg, out_a_on_compare_c);
      end else if (hit_a) begin
        wave_a_next = act(wave_a_reg, out_a_on_compare_a);
      end
      if (soft_trigger) begin
        wave_b_next = act(wave_b_reg, out_b_on_soft_trigger);
      end else if (ext_hit) begin
        wave_b_next = act(wave_b_reg, out_b_on_ext_event);
      end else if (hit_c) begin
        wave_b_next = act(wave_b_reg, out_b_on_compare_c);
      end else if (hit_b) begin
        wave_b_next = act(wave_b_reg, out_b_on_compare_b);
      end
    end
  end

  // ==========================================
  // Counter
  always @* begin
    count_next = count_reg;
    dir_down_next = dir_down_reg;
    if (soft_trigger || (ext_hit && ext_restart)) begin
      count_next = `TWC_CNT_ZERO;
      dir_down_next = 1'b0;
    end else if (running_reg) begin
      if (!wave) begin
        count_next = count_reg + `TWC_CNT_ONE;
      end else begin
        case (shape)
          `TWC_SHAPE_UP: begin
            count_next = count_reg + `TWC_CNT_ONE;
          end
          `TWC_SHAPE_UP_AUTO: begin
            if (hit_c) begin
              count_next = `TWC_CNT_ZERO;
            end else begin
              count_next = count_reg + `TWC_CNT_ONE;
            end
          end
          `TWC_SHAPE_UP_THEN_DOWN, `TWC_SHAPE_UP_THEN_DOWN_AUTO: begin
            if (!dir_down_reg) begin
              if ((shape == `TWC_SHAPE_UP_THEN_DOWN_AUTO && hit_c) ||
                  (shape == `TWC_SHAPE_UP_THEN_DOWN && count_reg == `TWC_CNT_MAX) ||
                  count_reg == `TWC_CNT_MAX) begin
                dir_down_next = 1'b1;
                count_next = count_reg - `TWC_CNT_ONE;
              end else begin
                count_next = count_reg + `TWC_CNT_ONE;
              end
            end else if (count_reg == `TWC_CNT_ZERO) begin
              dir_down_next = 1'b0;
              count_next = `TWC_CNT_ONE;
            end else begin
              count_next = count_reg - `TWC_CNT_ONE;
            end
          end
          default: begin
            count_next = count_reg;
          end
        endcase
      end
    end
  end

  // ==========================================
  // Gray stepper: 00 01 11 10 upward
  always @* begin
    if (gray_down) begin
      gray_next = {~gray_reg[0], gray_reg[1]};
    end else begin
      gray_next = {gray_reg[0], ~gray_reg[1]};
    end
  end

  // ==========================================
  // External event synchroniser
  always @(posedge clk) begin
    if (reset) begin
      ext_s1_reg <= 1'b0;
      ext_s2_reg <= 1'b0;
      ext_s3_reg <= 1'b0;
    end else begin
      ext_s1_reg <= ext_event;
      ext_s2_reg <= ext_s1_reg;
      ext_s3_reg <= ext_s2_reg;
    end
  end

  // ==========================================
  // Counter state
  always @(posedge clk) begin
    if (reset) begin
      count_reg <= `TWC_CNT_ZERO;
      dir_down_reg <= 1'b0;
    end else begin
      count_reg <= count_next;
      dir_down_reg <= dir_down_next;
    end
  end

  // ==========================================
  // Run control
  // Disable wins over enable when both are written at once
  always @(posedge clk) begin
    if (reset) begin
      running_reg <= 1'b0;
    end else if (wr_ctl && wdata[`TWC_CTL_DISABLE]) begin
      running_reg <= 1'b0;
    end else if (wr_ctl && wdata[`TWC_CTL_ENABLE]) begin
      running_reg <= 1'b1;
    end
  end

  // ==========================================
  // Waveform levels and stepper
  // Stepper advances only while selected, so it resumes where it stopped
  always @(posedge clk) begin
    if (reset) begin
      wave_a_reg <= 1'b0;
      wave_b_reg <= 1'b0;
      gray_reg <= 2'h0;
    end else begin
      wave_a_reg <= wave_a_next;
      wave_b_reg <= wave_b_next;
      if (gray_count_enable) begin
        gray_reg <= gray_next;
      end
    end
  end

  // ==========================================
  // Pin outputs, straight from flip-flops
  always @(posedge clk) begin
    if (reset) begin
      output_a <= 1'b0;
      output_b <= 1'b0;
    end else if (gray_count_enable) begin
      output_a <= gray_next[0];
      output_b <= gray_next[1];
    end else begin
      output_a <= wave_a_next;
      output_b <= wave_b_next;
    end
  end

  // ==========================================
  // Protect, mode and stepper registers
  // Protect itself stays writable, or it could never be lifted
  always @(posedge clk) begin
    if (reset) begin
      protect_reg <= 1'b0;
      mode_reg <= `TWC_WORD_ZERO;
      stepper_reg <= 2'h0;
    end else begin
      if (wr_protect) begin
        protect_reg <= wdata[`TWC_PROT_ENABLE];
      end
      if (wr_mode) begin
        mode_reg <= wdata;
      end
      if (wr_stepper) begin
        stepper_reg <= wdata[1:0];
      end
    end
  end

  // ==========================================
  // Compare registers, 16 bits wide
  always @(posedge clk) begin
    if (reset) begin
      compare_a_reg <= `TWC_CNT_ZERO;
      compare_b_reg <= `TWC_CNT_ZERO;
      compare_c_reg <= `TWC_CNT_ZERO;
    end else begin
      if (wr_cmp_a) begin
        compare_a_reg <= wdata[`TWC_CW-1:0];
      end
      if (wr_cmp_b) begin
        compare_b_reg <= wdata[`TWC_CW-1:0];
      end
      if (wr_cmp_c) begin
        compare_c_reg <= wdata[`TWC_CW-1:0];
      end
    end
  end

  // ==========================================
  // Read data, standing one cycle after the strobe
  always @(posedge clk) begin
    if (reset) begin
      rdata <= `TWC_WORD_ZERO;
    end else if (rd) begin
      case (addr)
        `TWC_ADDR_CONTROL: begin
          rdata <= {29'h0000000, output_b, output_a, running_reg};
        end
        `TWC_ADDR_MODE: begin
          rdata <= mode_reg;
        end
        `TWC_ADDR_STEPPER: begin
          rdata <= {30'h0000000, stepper_reg};
        end
        `TWC_ADDR_COUNT: begin
          rdata <= {`TWC_UPPER_ZERO, count_reg};
        end
        `TWC_ADDR_CMP_A: begin
          rdata <= {`TWC_UPPER_ZERO, compare_a_reg};
        end
        `TWC_ADDR_CMP_B: begin
          rdata <= {`TWC_UPPER_ZERO, compare_b_reg};
        end
        `TWC_ADDR_CMP_C: begin
          rdata <= {`TWC_UPPER_ZERO, compare_c_reg};
        end
        `TWC_ADDR_PROTECT: begin
          rdata <= {31'h0000000, protect_reg};
        end
        default: begin
          rdata <= `TWC_WORD_ZERO;
        end
      endcase
    end else begin
      rdata <= `TWC_WORD_ZERO;
    end
  end

endmodule

// *** logic/twc_defs.vh ***
// Register map, field positions and reset values of the timer waveform channel
`ifndef TWC_DEFS_VH
`define TWC_DEFS_VH
// ==========================================
// Register byte addresses
`define TWC_ADDR_CONTROL 32'h40010000
`define TWC_ADDR_MODE 32'h40010004
`define TWC_ADDR_STEPPER 32'h40010008
`define TWC_ADDR_COUNT 32'h40010010
`define TWC_ADDR_CMP_A 32'h40010014
`define TWC_ADDR_CMP_B 32'h40010018
`define TWC_ADDR_CMP_C 32'h4001001C
`define TWC_ADDR_PROTECT 32'h400100F0
// ==========================================
// Widths and reset values
`define TWC_CW 16
`define TWC_CNT_MAX 16'hFFFF
`define TWC_CNT_ZERO 16'h0000
`define TWC_CNT_ONE 16'h0001
`define TWC_WORD_ZERO 32'h00000000
`define TWC_UPPER_ZERO 16'h0000
// ==========================================
// Control register bits (write: commands, read: state)
`define TWC_CTL_ENABLE 0
`define TWC_CTL_DISABLE 1
`define TWC_CTL_SWTRIG 2
`define TWC_CTL_RUNNING 0
`define TWC_CTL_LEVEL_A 1
`define TWC_CTL_LEVEL_B 2
// ==========================================
// Mode register fields
`define TWC_MODE_EDGE_LO 8
`define TWC_MODE_EDGE_HI 9
`define TWC_MODE_EXT_RESTART 12
`define TWC_MODE_SHAPE_LO 13
`define TWC_MODE_SHAPE_HI 14
`define TWC_MODE_WAVE 15
`define TWC_MODE_A_CMPA_LO 16
`define TWC_MODE_A_CMPC_LO 18
`define TWC_MODE_A_EXT_LO 20
`define TWC_MODE_A_SW_LO 22
`define TWC_MODE_B_CMPB_LO 24
`define TWC_MODE_B_CMPC_LO 26
`define TWC_MODE_B_EXT_LO 28
`define TWC_MODE_B_SW_LO 30
// ==========================================
// Stepper and protect register bits
`define TWC_STEP_GRAY 0
`define TWC_STEP_DOWN 1
`define TWC_PROT_ENABLE 0
// ==========================================
// Encodings
`define TWC_SHAPE_UP 2'h0
`define TWC_SHAPE_UP_THEN_DOWN 2'h1
`define TWC_SHAPE_UP_AUTO 2'h2
`define TWC_SHAPE_UP_THEN_DOWN_AUTO 2'h3
`define TWC_ACT_NONE 2'h0
`define TWC_ACT_SET 2'h1
`define TWC_ACT_CLEAR 2'h2
`define TWC_ACT_TOGGLE 2'h3
`define TWC_EDGE_NONE 2'h0
`define TWC_EDGE_RISE 2'h1
`define TWC_EDGE_FALL 2'h2
`define TWC_EDGE_BOTH 2'h3
`define TWC_GRAY_ONE 2'h1
`endif

// *** sim/twc_checker_asserts.sv ***
// Port checker for the timer waveform channel
`timescale 1ns/1ps
`include "twc_defs.vh"
module twc_checker (
  input wire clk,
  input wire reset,
  input wire [31:0] addr,
  input wire [31:0] wdata,
  input wire wr,
  input wire rd,
  input wire [31:0] rdata,
  input wire ext_event,
  input wire output_a,
  input wire output_b
);
  // ==========================================
  // Shadow of accepted writes
  reg [31:0] mode_q;
  reg [1:0] step_q;
  reg prot_q;
  reg [15:0] cmpa_q;
  reg [15:0] cmpb_q;
  wire open_w = wr && !prot_q;
  always @(posedge clk) begin
    if (reset) begin
      mode_q <= 32'h0;
      step_q <= 2'h0;
      prot_q <= 1'h0;
      cmpa_q <= 16'h0;
      cmpb_q <= 16'h0;
    end else begin
      if (wr && addr == `TWC_ADDR_PROTECT) prot_q <= wdata[0];
      if (open_w && addr == `TWC_ADDR_MODE) mode_q <= wdata;
      if (open_w && addr == `TWC_ADDR_STEPPER) step_q <= wdata[1:0];
      if (open_w && mode_q[15] && addr == `TWC_ADDR_CMP_A) cmpa_q <= wdata[15:0];
      if (open_w && mode_q[15] && addr == `TWC_ADDR_CMP_B) cmpb_q <= wdata[15:0];
    end
  end
  function automatic logic act(input logic cur, input logic [1:0] c);
    act = c[0] ? (c[1] ? ~cur : 1'h1) : (c[1] ? 1'h0 : cur);
  endfunction
  // ==========================================
  // Properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_rd(a);
    rd && addr == a;
  endsequence
  sequence s_trig;
    wr && addr == `TWC_ADDR_CONTROL && wdata[2] && mode_q[15] && !step_q[0];
  endsequence
  // Three settled cycles, so the hand-over from waveform levels is skipped
  sequence s_gray;
    step_q[0] && $past(step_q) == step_q && $past(step_q, 3) == step_q;
  endsequence
  a_count_upper_zero: assert property (
    s_rd(`TWC_ADDR_COUNT) |=> rdata[31:16] == 16'h0) else $error("count upper bits set");
  a_cmpa_readback: assert property (
    s_rd(`TWC_ADDR_CMP_A) |=> rdata == {16'h0, $past(cmpa_q)}) else $error("compare a wrong");
  a_cmpb_readback: assert property (
    s_rd(`TWC_ADDR_CMP_B) |=> rdata == {16'h0, $past(cmpb_q)}) else $error("compare b wrong");
  a_mode_protected: assert property (
    s_rd(`TWC_ADDR_MODE) |=> rdata == $past(mode_q)) else $error("mode value wrong");
  a_step_protected: assert property (
    s_rd(`TWC_ADDR_STEPPER) |=> rdata[1:0] == $past(step_q)) else $error("stepper wrong");
  a_trig_sets_a: assert property (
    s_trig |=> output_a == act($past(output_a), mode_q[23:22])) else $error("trigger on a");
  a_trig_sets_b: assert property (
    s_trig |=> output_b == act($past(output_b), mode_q[31:30])) else $error("trigger on b");
  a_gray_one_step: assert property (
    s_gray |-> (output_a != $past(output_a)) != (output_b != $past(output_b))
    && (output_a != $past(output_a)) == (($past(output_a) == $past(output_b)) ^ step_q[1]))
    else $error("gray step wrong");
endmodule
bind twc_timer_channel twc_checker u_twc_checker (.clk(clk), .reset(reset), .addr(addr),
  .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .ext_event(ext_event),
  .output_a(output_a), .output_b(output_b));

// *** sim/twc_pin_model.sv ***
// Event source standing at the channel pins
`timescale 1ns/1ps
module twc_pin_model (
  input wire clk,
  output reg ext_event
);
  initial ext_event = 1'h0;
  // One edge, then enough cycles for the synchroniser and edge detect
  task flip;
    @(posedge clk);
    ext_event <= ~ext_event;
    repeat (5) @(posedge clk);
  endtask
endmodule

// *** sim/tb.sv ***
// Self-checking bench for the timer waveform channel
`timescale 1ns/1ps
`include "twc_defs.vh"
module tb;
  reg clk, reset, wr, rd;
  reg [31:0] addr, wdata, d, d0;
  wire [31:0] rdata;
  wire ext_event, output_a, output_b;
  reg ea, eb;
  integer num_errors = 0, samples_checked = 0, i;
  localparam [31:0] WAVE = 32'h00008000;
  twc_timer_channel u_twc_timer_channel (.clk(clk), .reset(reset), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .ext_event(ext_event),
    .output_a(output_a), .output_b(output_b));
  twc_pin_model u_twc_pin_model (.clk(clk), .ext_event(ext_event));
  initial begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end
  // ==========================================
  // Access and compare tasks
  task final_report;
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task check(input [31:0] got, input [31:0] exp);
    samples_checked = samples_checked + 1;
    if (got !== exp) begin
      num_errors = num_errors + 1;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task wreg(input [31:0] a, input [31:0] v);
    @(posedge clk);
    wr <= 1'h1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 1'h0;
  endtask
  task rreg(input [31:0] a, output [31:0] v);
    @(posedge clk);
    rd <= 1'h1;
    addr <= a;
    @(posedge clk);
    rd <= 1'h0;
    #1 v = rdata;
  endtask
  task rchk(input [31:0] a, input [31:0] e);
    rreg(a, d);
    check(d, e);
  endtask
  task outs(input [1:0] e);
    #1 check({30'h0, output_b, output_a}, {30'h0, e});
  endtask
  function act(input cur, input [1:0] c);
    act = c[0] ? (c[1] ? ~cur : 1'h1) : (c[1] ? 1'h0 : cur);
  endfunction
  // ==========================================
  // Main sequence
  initial begin
    reset = 1'h1;
    {wr, rd, addr, wdata} = 66'h0;
    repeat (6) @(posedge clk);
    reset <= 1'h0;
    for (i = 0; i < 2; i = i + 1) begin
      wreg(`TWC_ADDR_CMP_A + 4 * i, 32'hABCD1234);
      rchk(`TWC_ADDR_CMP_A + 4 * i, 32'h0);
    end
    wreg(`TWC_ADDR_MODE, WAVE);
    for (i = 0; i < 2; i = i + 1) begin
      wreg(`TWC_ADDR_CMP_A + 4 * i, 32'hABCD1234 + i);
      rchk(`TWC_ADDR_CMP_A + 4 * i, 32'h1234 + i);
    end
    wreg(`TWC_ADDR_COUNT, 32'h77);
    rchk(`TWC_ADDR_COUNT, 32'h0);
    wreg(`TWC_ADDR_PROTECT, 32'h1);
    wreg(`TWC_ADDR_MODE, 32'h0);
    wreg(`TWC_ADDR_CMP_A, 32'h5);
    wreg(`TWC_ADDR_STEPPER, 32'h1);
    rchk(`TWC_ADDR_MODE, WAVE);
    rchk(`TWC_ADDR_CMP_A, 32'h1234);
    rchk(`TWC_ADDR_STEPPER, 32'h0);
    wreg(`TWC_ADDR_PROTECT, 32'h0);
    rchk(32'h40010020, 32'h0);
    {ea, eb} = 2'h0;
    for (i = 0; i < 4; i = i + 1) begin
      wreg(`TWC_ADDR_MODE, WAVE | (i << 22) | ((3 - i) << 30));
      wreg(`TWC_ADDR_CONTROL, 32'h4);
      ea = act(ea, i);
      eb = act(eb, 3 - i);
      outs({eb, ea});
    end
    wreg(`TWC_ADDR_MODE, WAVE | (3 << 8) | (3 << 20) | (2 << 28));
    wreg(`TWC_ADDR_CONTROL, 32'h1);
    u_twc_pin_model.flip();
    outs(2'h0);
    u_twc_pin_model.flip();
    outs(2'h1);
    wreg(`TWC_ADDR_MODE, WAVE | (2 << 16) | (1 << 24));
    wreg(`TWC_ADDR_CMP_A, 32'h5);
    wreg(`TWC_ADDR_CMP_B, 32'h8);
    wreg(`TWC_ADDR_CONTROL, 32'h5);
    repeat (20) @(posedge clk);
    outs(2'h2);
    rreg(`TWC_ADDR_COUNT, d0);
    rreg(`TWC_ADDR_COUNT, d);
    check(d - d0, 32'h2);
    wreg(`TWC_ADDR_MODE, WAVE | (1 << 13));
    wreg(`TWC_ADDR_CONTROL, 32'h4);
    repeat (10) @(posedge clk);
    rchk(`TWC_ADDR_COUNT, 32'hB);
    wreg(`TWC_ADDR_CMP_C, 32'h6);
    for (i = 2; i < 4; i = i + 1) begin
      wreg(`TWC_ADDR_MODE, WAVE | (i << 13) | ((i - 1) << 18) | ((4 - i) << 26));
      wreg(`TWC_ADDR_CONTROL, 32'h4);
      repeat (8) begin
        rreg(`TWC_ADDR_COUNT, d);
        check({31'h0, d <= 32'h6}, 32'h1);
      end
      outs(i == 2 ? 2'h1 : 2'h2);
    end
    for (i = 0; i < 2; i = i + 1) begin
      wreg(`TWC_ADDR_STEPPER, 32'h1 | (i << 1));
      @(posedge clk);
      #1 d0 = {output_b, output_a};
      repeat (4) @(posedge clk);
      outs(d0[1:0]);
    end
    wreg(`TWC_ADDR_STEPPER, 32'h0);
    repeat (2) @(posedge clk);
    outs(2'h2);
    @(posedge clk);
    reset <= 1'h1;
    repeat (6) @(posedge clk);
    reset <= 1'h0;
    outs(2'h0);
    rchk(`TWC_ADDR_MODE, 32'h0);
    final_report;
  end
  // Hang guard
  initial begin
    repeat (5000) @(posedge clk);
    num_errors = num_errors + 1;
    final_report;
  end
endmodule
